// File: phy_autoneg_register_set.sv
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
// Overview of operation
// - identifier low word holds vendor bits 15:10, model 9:4, revision 3:0.
// - advertisement bit 15 read-write, requests next-page exchange when set.
// - advertisement bit 13 read-write, sends local remote fault when set.
// - advertisement bits 12:11 and 9 read zero and ignore writes.
// - advertisement bit 10 read-write pause ability, ability bit A5.
// - advertisement bit 8 read-write, 100 Mbit/s full duplex, A3.
// - advertisement bit 7 read-write, 100 Mbit/s half duplex, A2.
// - advertisement bit 6 read-write, 10 Mbit/s full duplex, A1.
// - advertisement bit 5 read-write, 10 Mbit/s half duplex, A0.
// - advertisement bits 4:0 are a fixed read-only selector.
// - partner word loaded from received base page when negotiation completes.
// - partner word: next page 15, ack 14, fault 13, ability 12:5, selector 4:0.
// - expansion bit 4 latches parallel detection fault until cleared.
// - expansion bit 3 shows partner next-page ability.
// - expansion bit 2 shows local next-page ability.
// - expansion bit 1 latches page received until cleared.
// - expansion bit 0 shows partner auto-negotiation ability.
// - latched-high bits capture high source and clear on register read.
module phy_autoneg_register_set (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] partner_page,
  input wire logic negotiation_done,
  input wire logic page_received_pulse,
  input wire logic parallel_fault_pulse,
  input wire logic partner_next_page_able,
  input wire logic partner_negotiation_able,
  input wire logic local_next_page_able,
  output logic [15:0] advertised_page
);
  import phy_an_pkg::*;

  typedef struct packed {
    logic wr_pend;
    logic [ADDR_DECODE_W-1:0] wr_addr;
    logic [15:0] adv;
    logic [15:0] partner;
    logic done_seen;
    logic [31:0] rdata;
    logic [15:0] adv_out;
    logic ready;
    logic resp;
  } state_t;
  state_t st;
  state_t next_st;

  // ----------------------------------------------------------------
  // pin inputs from the negotiation engine
  // ----------------------------------------------------------------
  localparam int SYNC_W = 16 + 6;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic [15:0] page_s;
  logic done_s;
  logic page_rx_s;
  logic fault_s;
  logic lp_np_s;
  logic lp_an_s;
  logic loc_np_s;

  // all engine levels share one two-stage synchroniser
  assign raw_in = {partner_page, negotiation_done, page_received_pulse,
                   parallel_fault_pulse, partner_next_page_able,
                   partner_negotiation_able, local_next_page_able};

  sync_2ff #(.W(SYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(raw_in),
    .q(sync_in)
  );

  // synchronised levels split back out
  assign {page_s, done_s, page_rx_s, fault_s, lp_np_s, lp_an_s, loc_np_s} = sync_in;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic access;
  logic rd_access;
  logic [ADDR_DECODE_W-1:0] a_addr;
  logic rd_expansion;

  assign access = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rd_access = access && !hwrite;
  assign a_addr = haddr[ADDR_DECODE_W-1:0];
  assign rd_expansion = rd_access && (a_addr == ADDR_EXPANSION);

  // ----------------------------------------------------------------
  // register hits of the address phase
  // ----------------------------------------------------------------
  logic hit_id;
  logic hit_adv;
  logic hit_partner;
  logic hit_expansion;
  logic hit_status;

  // one hit per mapped word; a hole in the map hits nothing
  assign hit_id = (a_addr == ADDR_ID_LOW);
  assign hit_adv = (a_addr == ADDR_ADV);
  assign hit_partner = (a_addr == ADDR_PARTNER);
  assign hit_expansion = (a_addr == ADDR_EXPANSION);
  assign hit_status = (a_addr == ADDR_ENGINE_STATUS);

  // ----------------------------------------------------------------
  // latched-high expansion flags
  // ----------------------------------------------------------------
  logic fault_flag;
  logic page_flag;

  sticky_flag u_fault (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(fault_s),
    .clear(rd_expansion),
    .flag(fault_flag)
  );

  sticky_flag u_page (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(page_rx_s),
    .clear(rd_expansion),
    .flag(page_flag)
  );

  // ----------------------------------------------------------------
  // read word assembly
  // ----------------------------------------------------------------
  logic [15:0] id_word;
  logic [15:0] exp_word;
  logic [15:0] status_word;
  logic [15:0] rd_word;
  logic [5:0] vendor_code_upper_bits;
  logic [5:0] model_number_field;
  logic [3:0] revision_number_field;

  // fixed identifier fields, values arbitrary
  assign vendor_code_upper_bits = VENDOR_CODE_UPPER;
  assign model_number_field = MODEL_NUMBER;
  assign revision_number_field = REVISION_NUMBER;
  assign id_word = {vendor_code_upper_bits, model_number_field, revision_number_field};
  // engine status word, bit 0 the synchronised done level delayed one more cycle by done_seen
  assign status_word = {15'h0000, st.done_seen};

  // ----------------------------------------------------------------
  // expansion sources
  // ----------------------------------------------------------------
  logic parallel_detect_fault;
  logic page_received_flag;
  logic partner_np_live;
  logic local_np_live;
  logic partner_an_live;

  // latched and live sources under their field names
  assign parallel_detect_fault = fault_flag;
  assign page_received_flag = page_flag;
  assign partner_np_live = lp_np_s;
  assign local_np_live = loc_np_s;
  assign partner_an_live = lp_an_s;

  // expansion word, reserved bits zero
  always_comb begin
    exp_word = 16'h0000;
    exp_word[EXP_PAR_FAULT] = parallel_detect_fault;
    exp_word[EXP_PARTNER_NP] = partner_np_live;
    exp_word[EXP_LOCAL_NP] = local_np_live;
    exp_word[EXP_PAGE_RX] = page_received_flag;
    exp_word[EXP_PARTNER_AN] = partner_an_live;
  end

  // ----------------------------------------------------------------
  // advertisement fields as sent on the base page
  // ----------------------------------------------------------------
  logic next_page_flag;
  logic remote_fault_flag;
  logic pause_ability;
  logic fast_full_duplex_ability;
  logic fast_half_duplex_ability;
  logic slow_full_duplex_ability;
  logic slow_half_duplex_ability;
  logic [15:0] adv_word;

  // writable ability bits of the stored word
  assign next_page_flag = st.adv[ADV_NEXT_PAGE];
  assign remote_fault_flag = st.adv[ADV_REMOTE_FAULT];
  assign pause_ability = st.adv[ADV_PAUSE];
  assign fast_full_duplex_ability = st.adv[ADV_FAST_FULL];
  assign fast_half_duplex_ability = st.adv[ADV_FAST_HALF];
  assign slow_full_duplex_ability = st.adv[ADV_SLOW_FULL];
  assign slow_half_duplex_ability = st.adv[ADV_SLOW_HALF];

  // unimplemented bits and selector come from the reset word
  always_comb begin
    adv_word = ADV_RESET;
    adv_word[ADV_NEXT_PAGE] = next_page_flag;
    adv_word[ADV_REMOTE_FAULT] = remote_fault_flag;
    adv_word[ADV_PAUSE] = pause_ability;
    adv_word[ADV_FAST_FULL] = fast_full_duplex_ability;
    adv_word[ADV_FAST_HALF] = fast_half_duplex_ability;
    adv_word[ADV_SLOW_FULL] = slow_full_duplex_ability;
    adv_word[ADV_SLOW_HALF] = slow_half_duplex_ability;
  end

  // ----------------------------------------------------------------
  // partner base page fields
  // ----------------------------------------------------------------
  logic partner_next_page;
  logic partner_ack;
  logic partner_remote_fault;
  logic [7:0] partner_tech_ability;
  logic [4:0] partner_selector;
  logic [15:0] partner_word;

  // fields of the stored partner page
  assign {partner_next_page, partner_ack, partner_remote_fault, partner_tech_ability,
          partner_selector} = st.partner;
  // fields back onto the read bus in page order
  assign partner_word = {partner_next_page, partner_ack, partner_remote_fault,
                         partner_tech_ability, partner_selector};

  // read mux; a hole in the map reads zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit_id) begin
      rd_word = id_word;
    end
    if (hit_adv) begin
      rd_word = adv_word;
    end
    if (hit_partner) begin
      rd_word = partner_word;
    end
    if (hit_expansion) begin
      rd_word = exp_word;
    end
    if (hit_status) begin
      rd_word = status_word;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [15:0] wr_val;
  logic load_partner;
  logic commit_adv;

  // only writable bits follow the write data
  always_comb begin
    wr_val = st.adv;
    wr_val[ADV_NEXT_PAGE] = hwdata[ADV_NEXT_PAGE];
    wr_val[ADV_REMOTE_FAULT] = hwdata[ADV_REMOTE_FAULT];
    wr_val[ADV_PAUSE] = hwdata[ADV_PAUSE];
    wr_val[ADV_FAST_FULL] = hwdata[ADV_FAST_FULL];
    wr_val[ADV_FAST_HALF] = hwdata[ADV_FAST_HALF];
    wr_val[ADV_SLOW_FULL] = hwdata[ADV_SLOW_FULL];
    wr_val[ADV_SLOW_HALF] = hwdata[ADV_SLOW_HALF];
  end
  // rising edge of the synchronised done level
  assign load_partner = done_s && !st.done_seen;
  // data phase of an advertisement write
  assign commit_adv = st.wr_pend && (st.wr_addr == ADDR_ADV);

  always_comb begin
    next_st = st;
    // address phase captured for write data phase
    next_st.wr_pend = access && hwrite;
    if (access) begin
      next_st.wr_addr = a_addr;
    end
    if (commit_adv) begin
      next_st.adv = wr_val;
    end
    // fixed bits forced back to the reset word
    next_st.adv = (next_st.adv & ADV_WRITE_MASK) | ADV_RESET;
    // load base page on completion edge
    next_st.done_seen = done_s;
    if (load_partner) begin
      next_st.partner = page_s;
    end
    // read data registered into the data phase
    if (rd_access) begin
      next_st.rdata = {16'h0000, rd_word};
    end
    // registered copy for the engine
    next_st.adv_out = next_st.adv;
    // bus response flops: zero wait states, always OKAY
    next_st.ready = 1'b1;
    next_st.resp = HRESP_OKAY;
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.wr_pend <= 1'b0;
      st.wr_addr <= '0;
      st.adv <= ADV_RESET;
      st.partner <= 16'h0000;
      st.done_seen <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.adv_out <= ADV_RESET;
      st.ready <= 1'b1;
      st.resp <= HRESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output straight from a flop
  assign hreadyout = st.ready;
  assign hresp = st.resp;
  // read data registered at the address phase edge
  assign hrdata = st.rdata;
  // advertisement copy for the engine
  assign advertised_page = st.adv_out;
endmodule

// File: phy_an_pkg.sv
package phy_an_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ID_LOW = 8'h0C;
  localparam logic [7:0] ADDR_ADV = 8'h10;
  localparam logic [7:0] ADDR_PARTNER = 8'h14;
  localparam logic [7:0] ADDR_EXPANSION = 8'h18;
  localparam logic [7:0] ADDR_ENGINE_STATUS = 8'h1C;
  localparam int ADDR_DECODE_W = 8;

  // ----------------------------------------------------------------
  // identifier fields (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [5:0] VENDOR_CODE_UPPER = 6'h2A; // arbitrary value
  localparam logic [5:0] MODEL_NUMBER = 6'h15; // arbitrary value
  localparam logic [3:0] REVISION_NUMBER = 4'h3; // arbitrary value

  // ----------------------------------------------------------------
  // advertisement layout
  // ----------------------------------------------------------------
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_REMOTE_FAULT = 13;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_FAST_FULL = 8;
  localparam int ADV_FAST_HALF = 7;
  localparam int ADV_SLOW_FULL = 6;
  localparam int ADV_SLOW_HALF = 5;
  // writable bits of the advertisement word
  localparam logic [15:0] ADV_WRITE_MASK = 16'hA5E0;
  localparam logic [4:0] SELECTOR_VALUE = 5'h01;
  localparam logic [15:0] ADV_RESET = 16'h0001;

  // ----------------------------------------------------------------
  // expansion layout
  // ----------------------------------------------------------------
  localparam int EXP_PAR_FAULT = 4;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_LOCAL_NP = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_PARTNER_AN = 0;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage

// File: sticky_flag.sv
`timescale 1ns/10ps
// latched-high flag: set wins over a read clear
module sticky_flag (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } state_t;
  state_t st;
  state_t next_st;

  // set has priority over clear
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.flag = 1'b0;
    end
    if (set) begin
      next_st.flag = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;
endmodule

// File: sync_2ff.sv
`timescale 1ns/10ps
// two flip-flop level synchroniser
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } state_t;
  state_t st;
  state_t next_st;

  // first stage only feeds second
  always_comb begin
    next_st.meta = d;
    next_st.sync = st.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.sync;
endmodule

// File: phy_an_sva.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// bus and register checks
// ----------------------------------------------------------------
module phy_an_sva
  import phy_an_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [15:0] advertised_page
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // read address phase taken
  sequence rd(a);
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr[7:0] == a;
  endsequence
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_okay_resp: assert property (hresp == HRESP_OKAY) else $error("bad response");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper data set");
  a_id_read: assert property (rd(ADDR_ID_LOW) |=>
    hrdata == {16'h0, VENDOR_CODE_UPPER, MODEL_NUMBER, REVISION_NUMBER}) else $error("id word");
  a_sel_fixed: assert property (advertised_page[4:0] == SELECTOR_VALUE)
    else $error("selector moved");
  a_unimpl_zero: assert property (advertised_page[12:11] == 2'h0 && !advertised_page[9])
    else $error("unimplemented bit set");
  a_adv_reset: assert property ($rose(hresetn) |-> advertised_page == ADV_RESET)
    else $error("advertisement reset");
  a_adv_read: assert property (rd(ADDR_ADV) |=>
    hrdata[4:0] == SELECTOR_VALUE && !hrdata[14]) else $error("advertisement read");
  a_exp_resv: assert property (rd(ADDR_EXPANSION) |=> hrdata[15:5] == 11'h0)
    else $error("expansion reserved");
  a_unmapped_zero: assert property (rd(8'h40) |=> hrdata == 32'h0) else $error("unmapped read");
endmodule

bind phy_autoneg_register_set phy_an_sva u_phy_an_sva (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .advertised_page(advertised_page));

// File: an_engine_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// negotiation engine stand-in
// ----------------------------------------------------------------
module an_engine_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] page_in,
  input wire logic start,
  input wire logic [2:0] live,
  input wire logic [1:0] ev,
  output logic [15:0] partner_page,
  output logic negotiation_done,
  output logic page_received_pulse,
  output logic parallel_fault_pulse,
  output logic partner_next_page_able,
  output logic local_next_page_able,
  output logic partner_negotiation_able
);
  // page and flags registered one cycle after the bench
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {partner_page, negotiation_done} <= '0;
      {page_received_pulse, parallel_fault_pulse} <= '0;
      {partner_next_page_able, local_next_page_able, partner_negotiation_able} <= '0;
    end else begin
      {partner_page, negotiation_done} <= {page_in, start};
      {page_received_pulse, parallel_fault_pulse} <= ev;
      {partner_next_page_able, local_next_page_able, partner_negotiation_able} <= live;
    end
  end
endmodule

// File: phy_autoneg_register_set_tb.sv
`timescale 1ns/10ps
module phy_autoneg_register_set_tb;
  import phy_an_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, start = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0, ev = '0;
  logic [2:0] live = '0;
  logic [15:0] page_in = '0, pp, adv;
  logic hreadyout, hresp, done, prp, pfp, pnp, lnp, pan;
  logic [31:0] idw = {16'h0, VENDOR_CODE_UPPER, MODEL_NUMBER, REVISION_NUMBER};
  int mismatches = 0, num_checks = 0, cyc = 0;
  // written value beside the value read back
  logic [15:0] rows [9][2] = '{'{16'hFFFF, 16'hA5E1}, '{16'h8000, 16'h8001},
    '{16'h2000, 16'h2001}, '{16'h0400, 16'h0401}, '{16'h1A00, 16'h0001},
    '{16'h01E0, 16'h01E1}, '{16'h4000, 16'h0001}, '{16'h001F, 16'h0001},
    '{16'h0000, 16'h0001}};

  an_engine_model u_an_engine_model (.hclk(hclk), .hresetn(hresetn), .page_in(page_in),
    .start(start), .live(live), .ev(ev), .partner_page(pp), .negotiation_done(done),
    .page_received_pulse(prp), .parallel_fault_pulse(pfp), .partner_next_page_able(pnp),
    .local_next_page_able(lnp), .partner_negotiation_able(pan));
  phy_autoneg_register_set u_phy_autoneg_register_set (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .partner_page(pp), .negotiation_done(done), .page_received_pulse(prp),
    .parallel_fault_pulse(pfp), .partner_next_page_able(pnp), .partner_negotiation_able(pan),
    .local_next_page_able(lnp), .advertised_page(adv));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #4 hclk = ~hclk;
  // cut a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer, address then data phase
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task end_of_test;
    $display("mismatches %0d num_checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(ADDR_ID_LOW, idw);
    rdchk(8'h40, 32'h0);
    xfer(1'b1, ADDR_ID_LOW, 32'hFFFF);
    rdchk(ADDR_ID_LOW, idw);
    rdchk(ADDR_ADV, 32'h1);
    foreach (rows[i]) begin
      xfer(1'b1, ADDR_ADV, {16'h0, rows[i][0]});
      rdchk(ADDR_ADV, {16'h0, rows[i][1]});
      chk({16'h0, adv}, {16'h0, rows[i][1]});
    end
    page_in <= 16'hC5A1;
    @(posedge hclk);
    start <= 1'b1;
    repeat (6) @(posedge hclk);
    rdchk(ADDR_ENGINE_STATUS, 32'h1);
    rdchk(ADDR_PARTNER, 32'hC5A1);
    page_in <= 16'h1234;
    repeat (6) @(posedge hclk);
    rdchk(ADDR_PARTNER, 32'hC5A1);
    start <= 1'b0;
    repeat (4) @(posedge hclk);
    start <= 1'b1;
    repeat (6) @(posedge hclk);
    rdchk(ADDR_PARTNER, 32'h1234);
    live <= 3'h7;
    ev <= 2'h3;
    @(posedge hclk);
    ev <= 2'h0;
    repeat (6) @(posedge hclk);
    rdchk(ADDR_EXPANSION, 32'h1F);
    rdchk(ADDR_EXPANSION, 32'h0D);
    live <= 3'h0;
    repeat (5) @(posedge hclk);
    rdchk(ADDR_EXPANSION, 32'h0);
    // source held high across a read: the set wins over the clear
    ev <= 2'h3;
    repeat (6) @(posedge hclk);
    rdchk(ADDR_EXPANSION, 32'h12);
    rdchk(ADDR_EXPANSION, 32'h12);
    ev <= 2'h0;
    repeat (6) @(posedge hclk);
    rdchk(ADDR_EXPANSION, 32'h12);
    rdchk(ADDR_EXPANSION, 32'h0);
    // mid-run reset with a non-reset advertisement and read data standing
    xfer(1'b1, ADDR_ADV, 32'hFFFF);
    rdchk(ADDR_ID_LOW, idw);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({16'h0, adv}, 32'h1);
    chk(hrdata, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(ADDR_ADV, 32'h1);
    end_of_test;
  end
endmodule
